//--- core/flash_cmd_pkg.sv
// Shared constants for the program/erase command path of a serial flash.
// Assumes a 25 MHz system clock on both ends and an SPI mode 0 link.
package flash_cmd_pkg;

  // Opcodes
  localparam logic [7:0] OPC_PROG_NO_ERASE = 8'h88;
  localparam logic [7:0] OPC_PAGE_ERASE = 8'h81;
  localparam logic [7:0] OPC_BLOCK_ERASE = 8'h50;
  localparam logic [7:0] OPC_SECTOR_ERASE = 8'h7C;

  // Frame and address layout
  localparam int CMD_BITS = 32;
  localparam int ADDR_BITS = 24;
  localparam int PAGE_BITS = 10;
  localparam int PAGE_LSB_264 = 9;
  localparam int PAGE_LSB_256 = 8;
  localparam int BLOCK_SEL_LSB = 3;
  localparam int UPPER_SECTOR_LSB = 7;

  // Page ranges touched by the erase kinds
  localparam logic [7:0] BLOCK_PAGES = 8'h08;
  localparam logic [7:0] SECTOR_PAGES = 8'h80;
  localparam logic [7:0] SECTOR0A_PAGES = 8'h08;
  localparam logic [7:0] SECTOR0B_PAGES = 8'h78;
  localparam logic [9:0] SECTOR0B_FIRST = 10'h008;

  // Self-timed work, per page; maximum times round down
  localparam int CLK_PERIOD_NS = 40;
  localparam int PROG_TIME_NS = 4000;
  localparam int ERASE_TIME_NS = 2000;
  localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES = ERASE_TIME_NS / CLK_PERIOD_NS;

  // Host serial clock: one half period in system clocks
  localparam int SCK_HALF_CYCLES = 2;

  typedef enum logic [1:0] {
    OP_PROG = 2'b00,
    OP_PAGE_ERASE = 2'b01,
    OP_BLOCK_ERASE = 2'b10,
    OP_SECTOR_ERASE = 2'b11
  } op_t;

endpackage

//--- core/flash_link_if.sv
// Serial link between the flash command host and the flash device.
// Assumes the testbench resolves the tri-stated serial output from miso_oe.
`timescale 1ns/1ns
`default_nettype none
interface flash_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe;

  modport device (input cs_n, input sck, input mosi, output miso, output miso_oe);
  modport host (output cs_n, output sck, output mosi, input miso, input miso_oe);
endinterface
`default_nettype wire

//--- core/flash_cmd_device.sv
// Device end: takes opcode and address on the link clock, starts the
// self-timed page program or erase on the system clock when chip select
// rises. Assumes the array itself sits on the user side of page_stb_o.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Opcode 88H programs buffer into erased page.
// - 264-byte pages: 5 ignored, 10 page, 9 ignored.
// - 256-byte pages: 6 ignored, BINARY_PAGE_BITS, 8 ignored.
// - Chip select rise starts program; busy meanwhile.
// - Page erased before programming; the host leaves this to the user.
// - Opcode 81H erases one page.
// - Page erase, 264 bytes: 5, 10, 9.
// - Page erase, 256 bytes: 6, BINARY_PAGE_BITS, 8.
// - Page erase sets bits to one, busy.
// - Opcode 50H erases eight consecutive pages.
// - Block erase, 264 bytes: 5, 7, 12.
// - Block erase, 256 bytes: 6, BINARY_BLOCK_SELECT_BITS, 11.
// - Block number from upper seven page bits.
// - Block erase on chip select rise, busy.
// - Opcode 7CH erases exactly one sector.
// - Sector 0a/0b, 264 bytes: 5, 7, 12.
// - Sectors 1-7, 264 bytes: 5, 3, 16.
// - Sector 0a/0b, 256 bytes: 6, BINARY_BLOCK_SELECT_BITS, 11.
// - Sectors 1-7, 256 bytes: 6, BINARY_UPPER_SECTOR_BITS, 15.
// - Sector decoded from page bits, any page.
// - Sector erase on chip select rise, busy.
// - Chip select low during command; rise tri-states.
module flash_cmd_device #(
  parameter int PROG_CYCLES = flash_cmd_pkg::PROG_CYCLES,
  parameter int ERASE_CYCLES = flash_cmd_pkg::ERASE_CYCLES
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  flash_link_if.device link,
  input wire logic page256_i,
  output logic busy_o,
  output logic page_stb_o,
  output logic [9:0] page_o,
  output logic erase_o,
  output flash_cmd_pkg::op_t op_o,
  output logic reject_o
);

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_WORK = 1'b1
  } state_t;

  // Page number out of the address bytes for the chosen page size
  function automatic logic [9:0] page_of(input logic [23:0] addr, input logic p256);
    if (p256)
      page_of = addr[flash_cmd_pkg::PAGE_LSB_256 +: flash_cmd_pkg::PAGE_BITS];
    else
      page_of = addr[flash_cmd_pkg::PAGE_LSB_264 +: flash_cmd_pkg::PAGE_BITS];
  endfunction

  // ---------------- link clock domain ----------------
  logic [5:0] bit_cnt_ff;
  logic [30:0] shift_ff;
  logic [31:0] word_ff;
  logic full_ff;

  // Bit count restarts whenever chip select is high
  always_ff @(posedge link.sck or posedge link.cs_n)
  begin
    if (link.cs_n)
      bit_cnt_ff <= 6'h00;
    else if (bit_cnt_ff != 6'h20)
      bit_cnt_ff <= bit_cnt_ff + 6'h01;
  end

  // Serial input, most significant bit first
  always_ff @(posedge link.sck or negedge arst_n_i)
  begin
    if (!arst_n_i)
      shift_ff <= 31'h0000_0000;
    else
      shift_ff <= {shift_ff[29:0], link.mosi};
  end

  // Opcode plus three address bytes captured on the 32nd edge
  always_ff @(posedge link.sck or negedge arst_n_i)
  begin
    if (!arst_n_i)
      word_ff <= 32'h0000_0000;
    else if (bit_cnt_ff == 6'h1F)
      word_ff <= {shift_ff, link.mosi};
  end

  // Frame complete flag; a new frame withdraws it on its first edge
  always_ff @(posedge link.sck or negedge arst_n_i)
  begin
    if (!arst_n_i)
      full_ff <= 1'b0;
    else if (bit_cnt_ff == 6'h1F)
      full_ff <= 1'b1;
    else if (bit_cnt_ff == 6'h00)
      full_ff <= 1'b0;
  end

  // No read data in these commands: output stays released
  assign link.miso = 1'b0;
  assign link.miso_oe = 1'b0;

  // ---------------- system clock domain ----------------
  logic cs_meta_ff;
  logic cs_sync_ff;
  logic cs_last_ff;
  logic full_meta_ff;
  logic full_sync_ff;
  logic frame_fresh_ff;
  logic cs_rise;

  // Synchronisers for chip select and the frame flag
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cs_meta_ff <= 1'b1;
      cs_sync_ff <= 1'b1;
      cs_last_ff <= 1'b1;
      full_meta_ff <= 1'b0;
      full_sync_ff <= 1'b0;
      frame_fresh_ff <= 1'b0;
    end
    else
    begin
      cs_meta_ff <= link.cs_n;
      cs_sync_ff <= cs_meta_ff;
      cs_last_ff <= cs_sync_ff;
      full_meta_ff <= full_ff;
      full_sync_ff <= full_meta_ff;
      // Old frame flag withdrawn inside this frame; blocks a bare chip select pulse
      frame_fresh_ff <= cs_rise ? 1'b0 : (frame_fresh_ff | (~cs_sync_ff & ~full_sync_ff));
    end
  end

  assign cs_rise = cs_sync_ff & ~cs_last_ff;

  // Decode of the captured word; stable while chip select is high
  logic [7:0] opcode;
  logic [9:0] cmd_page;
  logic known_op;
  flash_cmd_pkg::op_t dec_op;
  logic [9:0] first_page;
  logic [7:0] page_count;

  assign opcode = word_ff[31:24];
  assign cmd_page = page_of(word_ff[23:0], page256_i);

  // Opcode to operation, and the range of pages it covers
  always_comb
  begin
    known_op = 1'b1;
    dec_op = flash_cmd_pkg::OP_PROG;
    first_page = cmd_page;
    page_count = 8'h01;
    unique case (opcode)
      flash_cmd_pkg::OPC_PROG_NO_ERASE:
      begin
        dec_op = flash_cmd_pkg::OP_PROG;
      end
      flash_cmd_pkg::OPC_PAGE_ERASE:
      begin
        dec_op = flash_cmd_pkg::OP_PAGE_ERASE;
      end
      flash_cmd_pkg::OPC_BLOCK_ERASE:
      begin
        dec_op = flash_cmd_pkg::OP_BLOCK_ERASE;
        // Lowest three page bits do not matter
        first_page = {cmd_page[9:3], 3'h0};
        page_count = flash_cmd_pkg::BLOCK_PAGES;
      end
      flash_cmd_pkg::OPC_SECTOR_ERASE:
      begin
        dec_op = flash_cmd_pkg::OP_SECTOR_ERASE;
        if (cmd_page[9:7] != 3'h0)
        begin
          first_page = {cmd_page[9:7], 7'h00};
          page_count = flash_cmd_pkg::SECTOR_PAGES;
        end
        else if (cmd_page[9:3] == 7'h00)
        begin
          first_page = 10'h000;
          page_count = flash_cmd_pkg::SECTOR0A_PAGES;
        end
        else
        begin
          first_page = flash_cmd_pkg::SECTOR0B_FIRST;
          page_count = flash_cmd_pkg::SECTOR0B_PAGES;
        end
      end
      default:
      begin
        known_op = 1'b0;
      end
    endcase
  end

  // ---------------- self-timed sequencer ----------------
  state_t state_ff;
  logic [9:0] page_ff;
  logic [7:0] left_ff;
  logic [15:0] wait_ff;
  logic erase_ff;
  flash_cmd_pkg::op_t op_ff;
  logic start;
  logic step;
  logic [15:0] reload;

  // Start only on a full frame with a known opcode while idle
  assign start = cs_rise & full_sync_ff & frame_fresh_ff & known_op & (state_ff == ST_IDLE);
  assign step = (state_ff == ST_WORK) && (wait_ff == 16'h0000);
  assign reload = (dec_op == flash_cmd_pkg::OP_PROG) ?
                  16'(PROG_CYCLES - 1) : 16'(ERASE_CYCLES - 1);

  // Idle until chip select rises, work until the last page is done
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      state_ff <= ST_IDLE;
    else
    begin
      unique case (state_ff)
        ST_IDLE:
        begin
          if (start)
            state_ff <= ST_WORK;
        end
        ST_WORK:
        begin
          if (step && left_ff == 8'h01)
            state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Per-page wait counter
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      wait_ff <= 16'h0000;
    else if (start)
      wait_ff <= reload;
    else if (step)
      wait_ff <= erase_ff ? 16'(ERASE_CYCLES - 1) : 16'(PROG_CYCLES - 1);
    else if (state_ff == ST_WORK)
      wait_ff <= wait_ff - 16'h0001;
  end

  // Current page and pages still to go
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      page_ff <= 10'h000;
      left_ff <= 8'h00;
    end
    else if (start)
    begin
      page_ff <= first_page;
      left_ff <= page_count;
    end
    else if (step)
    begin
      page_ff <= page_ff + 10'h001;
      left_ff <= left_ff - 8'h01;
    end
  end

  // Kind of work held for the whole operation
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      erase_ff <= 1'b0;
      op_ff <= flash_cmd_pkg::OP_PROG;
    end
    else if (start)
    begin
      erase_ff <= (dec_op != flash_cmd_pkg::OP_PROG);
      op_ff <= dec_op;
    end
  end

  // Frame that ended short, unknown, or arrived while busy
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      reject_o <= 1'b0;
    else
      reject_o <= cs_rise & ~start;
  end

  assign busy_o = (state_ff == ST_WORK);
  assign page_stb_o = step;
  assign page_o = page_ff;
  assign erase_o = erase_ff;
  assign op_o = op_ff;

endmodule
`default_nettype wire

//--- core/flash_cmd_host.sv
// Host end: sends the first cmd_len_i bits (at most 32) of one opcode and three address bytes per request,
// making the serial clock from the system clock by a divider.
// Assumes the user has erased a page before asking to program it.
`timescale 1ns/1ns
`default_nettype none
module flash_cmd_host #(
  parameter int SCK_HALF = flash_cmd_pkg::SCK_HALF_CYCLES
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  flash_link_if.host link,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [7:0] cmd_opcode_i,
  input wire logic [9:0] cmd_page_i,
  input wire logic [5:0] cmd_len_i,
  input wire logic page256_i,
  output logic done_o
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LEAD = 3'b001,
    ST_SHIFT = 3'b010,
    ST_TRAIL = 3'b011,
    ST_GAP = 3'b100
  } state_t;

  // Address bytes for the chosen page size
  function automatic logic [23:0] addr_of(input logic [9:0] page, input logic p256);
    if (p256)
      addr_of = {6'h00, page, 8'h00};
    else
      addr_of = {5'h00, page, 9'h000};
  endfunction

  state_t state_ff;
  logic [15:0] div_ff;
  logic tick;
  logic [31:0] word_ff;
  logic [5:0] left_ff;
  logic sck_ff;
  logic cs_n_ff;

  assign tick = (div_ff == 16'(SCK_HALF - 1));
  assign cmd_ready_o = (state_ff == ST_IDLE);

  // Half-period divider, restarted by each accepted request
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      div_ff <= 16'h0000;
    else if (state_ff == ST_IDLE || tick)
      div_ff <= 16'h0000;
    else
      div_ff <= div_ff + 16'h0001;
  end

  // Frame sequence: lead, up to 32 clocks, trail, gap
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      state_ff <= ST_IDLE;
    else
    begin
      unique case (state_ff)
        ST_IDLE:
          if (cmd_valid_i)
            state_ff <= ST_LEAD;
        ST_LEAD:
          if (tick)
            state_ff <= (left_ff == 6'h00) ? ST_TRAIL : ST_SHIFT;
        ST_SHIFT:
          if (tick && sck_ff && left_ff == 6'h00)
            state_ff <= ST_TRAIL;
        ST_TRAIL:
          if (tick)
            state_ff <= ST_GAP;
        ST_GAP:
          if (tick)
            state_ff <= ST_IDLE;
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  // Serial clock, mode 0: rises mid-bit, idles low
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      sck_ff <= 1'b0;
    else if (state_ff == ST_SHIFT && tick)
      sck_ff <= ~sck_ff;
  end

  // Word loaded on request, shifted out after each falling edge
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      word_ff <= 32'h0000_0000;
      left_ff <= 6'h00;
    end
    else if (state_ff == ST_IDLE && cmd_valid_i)
    begin
      word_ff <= {cmd_opcode_i, addr_of(cmd_page_i, page256_i)};
      left_ff <= (cmd_len_i > 6'h20) ? 6'h20 : cmd_len_i;
    end
    else if (state_ff == ST_SHIFT && tick)
    begin
      if (!sck_ff)
        left_ff <= left_ff - 6'h01;
      else
        word_ff <= {word_ff[30:0], 1'b0};
    end
  end

  // Chip select low from lead through trail
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      cs_n_ff <= 1'b1;
    else if (state_ff == ST_IDLE && cmd_valid_i)
      cs_n_ff <= 1'b0;
    else if (state_ff == ST_TRAIL && tick)
      cs_n_ff <= 1'b1;
  end

  // Pulse when chip select goes back high
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      done_o <= 1'b0;
    else
      done_o <= (state_ff == ST_TRAIL) && tick;
  end

  assign link.cs_n = cs_n_ff;
  assign link.sck = sck_ff;
  assign link.mosi = word_ff[31];

endmodule
`default_nettype wire

//--- tb/flash_cmd_asserts.sv
// Concurrent checks on the link and the device's user side.
// Assumes one system clock for both ends; instantiated beside the link.
`timescale 1ns/1ns
`default_nettype none
module flash_cmd_asserts (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso_oe,
  input wire logic busy_o,
  input wire logic page_stb_o,
  input wire logic [9:0] page_o,
  input wire logic erase_o,
  input wire flash_cmd_pkg::op_t op_o,
  input wire logic reject_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // Link framing and serial clock
  serial_out_off_a: assert property (!miso_oe)
    else $error("serial output enabled");
  sck_idle_low_a: assert property (cs_n |-> !sck)
    else $error("serial clock high outside frame");
  mosi_hold_a: assert property (!cs_n && sck && $past(sck) |-> $stable(mosi))
    else $error("data moved while serial clock high");
  cs_high_gap_a: assert property ($rose(cs_n) |-> cs_n [*3])
    else $error("chip select high too short");

  // Start, refusal and end of the self-timed work
  busy_after_cs_a: assert property ($rose(busy_o) |-> $past(cs_n) && $past(cs_n, 2))
    else $error("busy rose without a chip select rise");
  reject_no_start_a: assert property (reject_o |-> $past(cs_n) && !$rose(busy_o))
    else $error("refused frame started work");
  stb_in_busy_a: assert property (page_stb_o |-> busy_o)
    else $error("page strobe while idle");
  erase_kind_a: assert property (page_stb_o |-> erase_o == (op_o != flash_cmd_pkg::OP_PROG))
    else $error("erase flag does not match operation");
  single_page_a: assert property (page_stb_o && (op_o == flash_cmd_pkg::OP_PROG
    || op_o == flash_cmd_pkg::OP_PAGE_ERASE) |=> !busy_o)
    else $error("single page work did not end");
  block_end_a: assert property (page_stb_o && op_o == flash_cmd_pkg::OP_BLOCK_ERASE
    && page_o[2:0] == 3'h7 |=> !busy_o)
    else $error("block erase ran past its eighth page");
  sector_end_a: assert property (page_stb_o && op_o == flash_cmd_pkg::OP_SECTOR_ERASE
    && page_o[6:0] == 7'h7F |=> !busy_o)
    else $error("sector erase ran past sector end");
  page_step_a: assert property (page_stb_o |=> !busy_o || page_o == $past(page_o) + 10'h001)
    else $error("page did not step by one");

  // Main scenarios reached
  cover property (page_stb_o && op_o == flash_cmd_pkg::OP_BLOCK_ERASE);
  cover property (page_stb_o && op_o == flash_cmd_pkg::OP_SECTOR_ERASE && page_o == 10'h3FF);
  cover property (reject_o);
endmodule
`default_nettype wire

//--- tb/test_serial_flash_program_erase_cmds.sv
// Bench joining host and device over the link; drives the host's user side.
// Assumes short self-timed counts set by parameters below.
`timescale 1ns/1ns
`default_nettype none
module test_serial_flash_program_erase_cmds;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic p256 = 1'b0;
  logic vld = 1'b0;
  logic [7:0] opc = 8'h00;
  logic [9:0] pg = 10'h000;
  logic [5:0] len = 6'h20;
  logic rdy, done, busy, stb, ers, rej;
  logic [9:0] page;
  flash_cmd_pkg::op_t op;
  logic [31:0] word;
  int nbits = 0;
  int err_count = 0;
  int n_compared = 0;

  flash_link_if lk();
  flash_cmd_host i_flash_cmd_host (.clk_i(clk), .arst_n_i(arst_n), .link(lk.host),
    .cmd_valid_i(vld), .cmd_ready_o(rdy), .cmd_opcode_i(opc), .cmd_page_i(pg),
    .cmd_len_i(len), .page256_i(p256), .done_o(done));
  flash_cmd_device #(.PROG_CYCLES(4), .ERASE_CYCLES(2)) i_flash_cmd_device (.clk_i(clk),
    .arst_n_i(arst_n), .link(lk.device), .page256_i(p256), .busy_o(busy),
    .page_stb_o(stb), .page_o(page), .erase_o(ers), .op_o(op), .reject_o(rej));
  flash_cmd_asserts i_flash_cmd_asserts (.clk_i(clk), .arst_n_i(arst_n), .cs_n(lk.cs_n),
    .sck(lk.sck), .mosi(lk.mosi), .miso_oe(lk.miso_oe), .busy_o(busy), .page_stb_o(stb),
    .page_o(page), .erase_o(ers), .op_o(op), .reject_o(rej));

  // System clock, 40 ns
  initial
  begin
    forever #20 clk = ~clk;
  end

  // Wire sniffer: bits as the device samples them
  always @(negedge lk.cs_n) nbits = 0;
  always @(posedge lk.sck)
  begin
    if (!lk.cs_n)
    begin
      word = {word[30:0], lk.mosi};
      nbits++;
    end
  end

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic timeout(input string what);
    err_count++;
    $display("CHECK FAILED %s expected event seen timeout", what);
    results();
  endtask

  // One host request, then the frame as seen on the wire
  task automatic send(input logic [7:0] o, input logic [9:0] p, input logic [5:0] n,
    input logic l);
    int i;
    @(negedge clk);
    for (i = 0; i < 50 && rdy !== 1'b1; i++)
      @(negedge clk);
    if (i == 50) timeout("host ready");
    opc = o;
    pg = p;
    len = n;
    p256 = l;
    vld = 1'b1;
    @(negedge clk);
    vld = 1'b0;
    for (i = 0; i < 400 && done !== 1'b1; i++)
      @(negedge clk);
    if (i == 400) timeout("host done");
    chk("frame bits", nbits, n);
    if (n == 6'h20)
      chk("frame word", word, {o, l ? {6'h00, p, 8'h00} : {5'h00, p, 9'h00}});
    chk("serial out enable", lk.miso_oe, 1'b0);
  endtask

  // Strobes of one operation, or its refusal
  task automatic watch(input logic [9:0] f, input int n, input logic er,
    input flash_cmd_pkg::op_t o, input logic exp_rej);
    int i;
    int k;
    logic seen_rej;
    logic seen_busy;
    k = 0;
    seen_rej = 1'b0;
    seen_busy = 1'b0;
    for (i = 0; i < 600; i++)
    begin
      @(negedge clk);
      if (rej === 1'b1) seen_rej = 1'b1;
      if (busy === 1'b1) seen_busy = 1'b1;
      if (stb === 1'b1)
      begin
        chk("page", page, f + k[9:0]);
        chk("erase flag", ers, er);
        chk("op kind", op, o);
        k++;
      end
      if (i > 8 && busy !== 1'b1 && (seen_rej || seen_busy)) break;
    end
    if (i == 600) timeout("device idle");
    chk("strobes", k, n);
    chk("reject", seen_rej, exp_rej);
  endtask

  task automatic op_run(input logic [7:0] o, input logic [9:0] p, input logic l,
    input logic [9:0] f, input int n);
    flash_cmd_pkg::op_t k;
    case (o)
      8'h88: k = flash_cmd_pkg::OP_PROG;
      8'h81: k = flash_cmd_pkg::OP_PAGE_ERASE;
      8'h50: k = flash_cmd_pkg::OP_BLOCK_ERASE;
      default: k = flash_cmd_pkg::OP_SECTOR_ERASE;
    endcase
    send(o, p, 6'h20, l);
    watch(f, n, o != 8'h88, k, 1'b0);
  endtask

  task automatic t_reset();
    chk("busy after reset", busy, 1'b0);
    chk("cs after reset", lk.cs_n, 1'b1);
    chk("sck after reset", lk.sck, 1'b0);
    $display("test reset done");
  endtask

  // Pages are erased before they are programmed
  task automatic t_program();
    op_run(8'h81, 10'h155, 1'b0, 10'h155, 1);
    op_run(8'h88, 10'h155, 1'b0, 10'h155, 1);
    op_run(8'h81, 10'h2AA, 1'b1, 10'h2AA, 1);
    op_run(8'h88, 10'h2AA, 1'b1, 10'h2AA, 1);
    $display("test program done");
  endtask

  task automatic t_block();
    op_run(8'h50, 10'h3FB, 1'b0, 10'h3F8, 8);
    op_run(8'h50, 10'h00C, 1'b1, 10'h008, 8);
    $display("test block done");
  endtask

  task automatic t_sector();
    op_run(8'h7C, 10'h005, 1'b0, 10'h000, 8);
    op_run(8'h7C, 10'h013, 1'b1, 10'h008, 120);
    op_run(8'h7C, 10'h1A5, 1'b0, 10'h180, 128);
    op_run(8'h7C, 10'h3FF, 1'b1, 10'h380, 128);
    $display("test sector done");
  endtask

  // Short frame and unknown opcode start nothing
  task automatic t_refuse();
    send(8'h81, 10'h010, 6'h1F, 1'b0);
    watch(10'h000, 0, 1'b0, flash_cmd_pkg::OP_PROG, 1'b1);
    send(8'h83, 10'h010, 6'h20, 1'b0);
    watch(10'h000, 0, 1'b0, flash_cmd_pkg::OP_PROG, 1'b1);
    $display("test refuse done");
  endtask

  // A frame during a sector erase is refused
  task automatic t_busy();
    int i;
    send(8'h7C, 10'h200, 6'h20, 1'b0);
    send(8'h88, 10'h001, 6'h20, 1'b0);
    for (i = 0; i < 8 && rej !== 1'b1; i++)
      @(negedge clk);
    chk("reject while busy", rej, 1'b1);
    chk("still busy", busy, 1'b1);
    for (i = 0; i < 600 && busy === 1'b1; i++)
      @(negedge clk);
    if (i == 600) timeout("busy end");
    chk("sector op kept", op, flash_cmd_pkg::OP_SECTOR_ERASE);
    // Bare chip select pulse must not replay the last full frame
    send(8'h88, 10'h001, 6'h00, 1'b0);
    watch(10'h000, 0, 1'b0, flash_cmd_pkg::OP_PROG, 1'b1);
    $display("test busy done");
  endtask

  initial
  begin
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    t_reset();
    t_program();
    t_block();
    t_sector();
    t_refuse();
    t_busy();
    results();
  end
endmodule
`default_nettype wire
